// [iowdt_pkg.sv]
// Constants shared by the I/O port watchdog files
package iowdt_pkg;
    localparam logic [15:0] PORT_ADDR = 16'h0443;
    localparam logic [7:0] CODE_MIN = 8'h01;
    localparam logic [7:0] CODE_MAX = 8'h3E;
    localparam logic [7:0] CODE_RESET = 8'h00;
    localparam int SEC_NS = 1000000000;
    localparam int CLK_NS = 8;
    localparam int TICKS_PER_SEC = SEC_NS / CLK_NS;
    localparam int CNT_W = 27;
    localparam logic [4:0] RESET_PULSE_CYC = 5'h10;
endpackage : iowdt_pkg

// [iowdt_tick_if.sv]
// One-second time base link between watchdog core and prescaler
`timescale 1ns/1ps
interface iowdt_tick_if;
    logic restart;
    logic tick;
    modport ctl (output restart, input tick);
    modport gen (input restart, output tick);
endinterface : iowdt_tick_if

// [iowdt_prescaler.sv]
// Divides mclk down to a one-cycle pulse once per second
`timescale 1ns/1ps
module iowdt_prescaler #(
    parameter int TICKS = iowdt_pkg::TICKS_PER_SEC
) (
    input wire logic mclk,
    input wire logic rstn,
    iowdt_tick_if.gen tickIf
);
    typedef struct packed {
        logic [iowdt_pkg::CNT_W-1:0] cnt;
        logic tick;
    } iowdt_pre_type;

    localparam logic [iowdt_pkg::CNT_W-1:0] LAST =
        iowdt_pkg::CNT_W'(TICKS - 1);

    iowdt_pre_type q;
    iowdt_pre_type d;

    always_comb begin
        d = q;
        // Restart realigns the second so a fresh interval is whole
        d.tick = !tickIf.restart && (q.cnt == LAST);
        if (tickIf.restart || q.cnt == LAST) begin
            d.cnt = '0;
        end else begin
            d.cnt = q.cnt + 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tickIf.tick = q.tick;
endmodule : iowdt_prescaler

// [iowdt_core.sv]
// Watchdog timer behind one 8-bit host I/O port
// Operation
// - Port write of a code 01..3E loads interval and starts countdown; any other code stops it
// - Codes 01..3E give 1..62 seconds
// - Each rewrite with a valid code reloads countdown with new code
// - Port read stops and disables countdown
// - Expiry asserts CPU reset or interrupt
`timescale 1ns/1ps
module iowdt_core #(
    parameter int TICKS_PER_SEC = iowdt_pkg::TICKS_PER_SEC
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [15:0] ioAddr,
    input wire logic ioWr,
    input wire logic ioRd,
    input wire logic [7:0] ioWrData,
    output logic [7:0] ioRdData,
    input wire logic resetMode,
    output logic cpuResetOut,
    output logic irqOut,
    output logic wdtActive
);
    typedef struct packed {
        logic enabled;
        logic [7:0] code;
        logic [5:0] secsLeft;
        logic [7:0] rdData;
        logic irq;
        logic [4:0] rstCnt;
        // Reset pin comes straight from a flop
        logic rstOut;
        // Two stages for the mode strap, which comes from a pin
        logic modeMeta;
        logic modeSync;
        // Assertion helper: cycles the reset pin has stood high
        logic [4:0] pulseRun;
    } iowdt_state_type;

    iowdt_state_type q;
    iowdt_state_type d;
    iowdt_tick_if tickIf ();
    logic portHit;
    logic wrHit;
    logic rdHit;
    logic codeValid;
    logic expire;
    logic strayAccess;

    // Restarted by every port write, so a refresh starts a whole second
    iowdt_prescaler #(
        .TICKS(TICKS_PER_SEC)
    ) u_prescaler (
        .mclk(mclk),
        .rstn(rstn),
        .tickIf(tickIf.gen)
    );

    // Only the one port decodes; every other address is ignored
    assign portHit = (ioAddr == iowdt_pkg::PORT_ADDR);
    assign wrHit = ioWr && portHit;
    assign strayAccess = (ioWr || ioRd) && !portHit;
    // A write in the same cycle as a read wins
    assign rdHit = ioRd && portHit && !ioWr;
    assign codeValid = (ioWrData >= iowdt_pkg::CODE_MIN) &&
        (ioWrData <= iowdt_pkg::CODE_MAX);
    // An access in the expiry cycle wins, so no action follows it
    assign expire = q.enabled && !wrHit && !rdHit && tickIf.tick &&
        (q.secsLeft == 6'h01);

    always_comb begin
        d = q;
        tickIf.restart = 1'b0;
        // Strap is only read after both stages
        d.modeMeta = resetMode;
        d.modeSync = q.modeMeta;
        if (q.rstCnt != 5'h00) begin
            d.rstCnt = q.rstCnt - 1'b1;
        end
        if (wrHit) begin
            d.code = ioWrData;
            d.enabled = codeValid;
            d.secsLeft = codeValid ? ioWrData[5:0] : 6'h00;
            d.irq = 1'b0;
            tickIf.restart = 1'b1;
        end else if (rdHit) begin
            d.rdData = q.code;
            d.enabled = 1'b0;
            d.irq = 1'b0;
        end else if (q.enabled && tickIf.tick) begin
            if (expire) begin
                d.enabled = 1'b0;
                // Strap is static; a late change moves only one expiry
                if (q.modeSync) begin
                    d.rstCnt = iowdt_pkg::RESET_PULSE_CYC;
                end else begin
                    d.irq = 1'b1;
                end
            end else begin
                d.secsLeft = q.secsLeft - 1'b1;
            end
        end
        // Taken from the next count so the pulse keeps its timing
        d.rstOut = (d.rstCnt != 5'h00);
        if (!q.rstOut) begin
            d.pulseRun = 5'h00;
        end else if (q.pulseRun != 5'h1F) begin
            d.pulseRun = q.pulseRun + 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q <= '{enabled: 1'b0, code: iowdt_pkg::CODE_RESET,
                secsLeft: 6'h00, rdData: 8'h00, irq: 1'b0,
                rstCnt: 5'h00, rstOut: 1'b0, modeMeta: 1'b0,
                modeSync: 1'b0, pulseRun: 5'h00};
        end else begin
            q <= d;
        end
    end

    assign ioRdData = q.rdData;
    assign cpuResetOut = q.rstOut;
    assign irqOut = q.irq;
    assign wdtActive = q.enabled;

    // Checks run on the one clock and pause while in reset
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    chk_write_starts: assert property (
        wrHit && codeValid |=> wdtActive &&
            q.secsLeft == $past(ioWrData[5:0]))
        else $error("valid write did not start countdown");

    chk_refresh_reload: assert property (
        wdtActive && wrHit && codeValid |=> wdtActive &&
            q.code == $past(ioWrData) && !irqOut)
        else $error("rewrite did not reload countdown");

    chk_code_range: assert property (
        wdtActive |-> q.secsLeft >= 6'h01 && q.secsLeft <= 6'h3E)
        else $error("countdown outside one to sixty-two");

    chk_second_step: assert property (
        wdtActive && tickIf.tick && !wrHit && !rdHit &&
            q.secsLeft > 6'h01 |=> q.secsLeft == $past(q.secsLeft) - 1'b1)
        else $error("countdown did not step once per second");

    chk_read_disable: assert property (
        rdHit |=> !wdtActive && ioRdData == $past(q.code))
        else $error("read did not disable timer");

    chk_idle_quiet: assert property (
        !wdtActive && !wrHit |=> !$rose(irqOut) && !$rose(cpuResetOut))
        else $error("timeout action while disabled");

    chk_invalid_code: assert property (
        wrHit && !codeValid |=> !wdtActive)
        else $error("invalid code left timer running");

    chk_expire_reset: assert property (
        expire && q.modeSync |=> cpuResetOut ##15 cpuResetOut ##1
            !cpuResetOut)
        else $error("reset pulse width wrong");

    chk_reset_width: assert property (
        $fell(cpuResetOut) |-> q.pulseRun == iowdt_pkg::RESET_PULSE_CYC)
        else $error("reset pulse did not stand sixteen cycles");

    chk_expire_irq: assert property (
        expire && !q.modeSync |=> irqOut && !wdtActive)
        else $error("expiry did not raise interrupt");

    chk_expire_stops: assert property (
        expire |=> !wdtActive)
        else $error("countdown kept running after expiry");

    chk_irq_hold: assert property (
        irqOut && !wrHit && !rdHit |=> irqOut)
        else $error("interrupt dropped without a port access");

    chk_access_clears: assert property (
        (wrHit || rdHit) |=> !irqOut)
        else $error("port access did not clear interrupt");

    chk_stray_ignored: assert property (
        strayAccess |=> $stable(q.code) && $stable(ioRdData))
        else $error("access to another address changed the port");

    chk_rdata_hold: assert property (
        !rdHit |=> $stable(ioRdData))
        else $error("read data changed without a read");

    chk_read_keeps_code: assert property (
        rdHit |=> q.code == $past(q.code))
        else $error("read changed the stored code");

    chk_code_kept: assert property (
        wrHit |=> q.code == $past(ioWrData))
        else $error("written code not stored");

    chk_tick_single: assert property (
        tickIf.tick |=> !tickIf.tick)
        else $error("second tick lasted more than one cycle");

    chk_restart_align: assert property (
        wrHit |=> !tickIf.tick)
        else $error("refresh did not restart the second");

    chk_no_early_action: assert property (
        wdtActive && q.secsLeft != 6'h01 |=> !$rose(irqOut) &&
            !$rose(cpuResetOut))
        else $error("timeout action before the last second");

    // Main scenarios
    cov_reset_expiry: cover property (expire && q.modeSync);
    cov_irq_expiry: cover property (expire && !q.modeSync);
    cov_refresh: cover property (wdtActive && wrHit && codeValid);
    cov_read_stop: cover property (wdtActive && rdHit);
    cov_stray_access: cover property (strayAccess);
endmodule : iowdt_core

// [iowdt_tb.sv]
// Self-checking bench for the I/O port watchdog core
`timescale 1ns/1ps
module iowdt_tb;
    localparam int T = 4;
    localparam logic [15:0] PA = iowdt_pkg::PORT_ADDR;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [15:0] ioAddr = 16'h0000;
    logic ioWr = 1'b0;
    logic ioRd = 1'b0;
    logic [7:0] ioWrData = 8'h00;
    logic resetMode = 1'b0;
    logic [7:0] ioRdData;
    logic cpuResetOut;
    logic irqOut;
    logic wdtActive;
    logic [10:0] expQ[$];
    logic [2:0] snap = 3'h0;
    logic rdHit = 1'b0;
    logic [16:0] lfsr = 17'h15DC5;
    logic [7:0] code;
    logic [7:0] badCodes[3] = '{8'h00, 8'h3F, 8'hFF};
    int badCount = 0;
    int samplesChecked = 0;
    iowdt_core #(.TICKS_PER_SEC(T)) dut_u (.mclk(mclk), .rstn(rstn),
        .ioAddr(ioAddr), .ioWr(ioWr), .ioRd(ioRd), .ioWrData(ioWrData),
        .ioRdData(ioRdData), .resetMode(resetMode),
        .cpuResetOut(cpuResetOut), .irqOut(irqOut), .wdtActive(wdtActive));
    initial forever #4 mclk = ~mclk;
    function automatic logic [7:0] randCode();
        lfsr = {lfsr[15:0], lfsr[16] ^ lfsr[13]};
        return 8'h01 + 8'(lfsr % 62);
    endfunction : randCode
    task automatic idle(int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : idle
    task automatic access(logic wr, logic [15:0] a, logic [7:0] d);
        ioWr = wr;
        ioRd = ~wr;
        ioAddr = a;
        ioWrData = d;
        @(posedge mclk);
        #1;
        ioWr = 1'b0;
        ioRd = 1'b0;
    endtask : access
    // Status bits: irq, cpu reset, active; seen as the read is taken
    task automatic readExp(logic [2:0] st, logic [7:0] d);
        expQ.push_back({st, d});
        access(1'b0, PA, 8'h00);
    endtask : readExp
    task automatic compare(logic [10:0] got, logic [10:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            badCount++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : compare
    task automatic finishTest();
        $display("Counts: checked=%0d bad=%0d", samplesChecked, badCount);
        if (badCount == 0 && samplesChecked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finishTest
    always @(posedge mclk) begin
        if (rdHit) begin
            if (expQ.size() == 0) begin
                compare({snap, ioRdData}, 11'h7FF);
            end else begin
                compare({snap, ioRdData}, expQ.pop_front());
            end
        end
        rdHit <= ioRd && !ioWr && ioAddr == PA;
        snap <= {irqOut, cpuResetOut, wdtActive};
    end
    initial begin
        #100000;
        badCount++;
        $display("Watchdog expired at %0t", $time);
        finishTest();
    end
    initial begin
        repeat (6) @(posedge mclk);
        #1;
        rstn = 1'b1;
        code = randCode();
        access(1'b1, PA, code);
        idle(code * T);
        readExp(3'h1, code);
        $display("Test load done");
        for (int m = 0; m < 2; m++) begin
            idle(20);
            resetMode = m[0];
            access(1'b1, PA, 8'h02);
            idle(2 * T + 1);
            readExp(m ? 3'h2 : 3'h4, 8'h02);
        end
        $display("Test expiry done");
        idle(20);
        access(1'b1, PA, 8'h01);
        repeat (6) begin
            idle(T);
            code = randCode();
            access(1'b1, PA, code);
        end
        idle(code * T);
        readExp(3'h1, code);
        idle(1);
        access(1'b1, PA, 8'h01);
        idle(1);
        readExp(3'h1, 8'h01);
        idle(2 * T + 4);
        readExp(3'h0, 8'h01);
        $display("Test refresh and stop done");
        foreach (badCodes[i]) begin
            idle(1);
            access(1'b1, PA, 8'h01);
            idle(1);
            access(1'b1, PA, badCodes[i]);
            idle(T + 2);
            readExp(3'h0, badCodes[i]);
        end
        idle(1);
        access(1'b1, 16'h0442, 8'h05);
        idle(1);
        readExp(3'h0, 8'hFF);
        $display("Test invalid codes done");
        idle(3);
        finishTest();
    end
endmodule : iowdt_tb
